/* logic/quad_dac_channel_register_control.v */
/*
 * Serial command decoder of a quad 14-bit converter: shifts in 24-bit
 * words, steers code, range and trim writes into four channels, runs the
 * function register, the two-bit auxiliary port and readback on sdo.
 * Assumes the link pins, supply detector and clamp request are
 * asynchronous to i_sys_clk and the link clock is far slower than it.
 * A read answer leaves on the frame that follows the read request.
 */
`timescale 1ns/1ps
`include "quad_dac_regs.vh"

module quad_dac_channel_register_control #(
   parameter CHANNELS = 4,
   parameter CODE_W   = 14,
   parameter RANGE_W  = 2,
   parameter TRIM_W   = 6
) (
   input  wire                          i_sys_clk,
   input  wire                          i_rst_b,
   input  wire                          i_link_clk,
   input  wire                          i_link_sync_n,
   input  wire                          i_link_din,
   output reg                           o_link_dout,
   output reg                           o_link_dout_oe,
   input  wire                          i_clamp_request_n,
   input  wire                          i_supply_ok,
   output reg                           o_supply_ok_out,
   input  wire                          i_aux_pin_low,
   output reg                           o_aux_pin_low,
   output reg                           o_aux_pin_low_oe,
   input  wire                          i_aux_pin_high,
   output reg                           o_aux_pin_high,
   output reg                           o_aux_pin_high_oe,
   output reg                           o_gnd_offset_en,
   output wire [CHANNELS*CODE_W-1:0]    o_code_field,
   output wire [CHANNELS*RANGE_W-1:0]   o_range_code,
   output wire [CHANNELS*TRIM_W-1:0]    o_trim_code,
   output wire [CHANNELS*(TRIM_W+1)-1:0] o_pos_fs_adj,
   output wire [CHANNELS*(TRIM_W+1)-1:0] o_neg_fs_adj,
   output wire [CHANNELS-1:0]           o_amp_gate,
   output wire [CHANNELS-1:0]           o_clamp_gate
);

   localparam NSYNC = 7;
   localparam S_AUX0 = 0;
   localparam S_AUX1 = 1;
   localparam S_SUP  = 2;
   localparam S_CLMP = 3;
   localparam S_DIN  = 4;
   localparam S_SYNC = 5;
   localparam S_CLK  = 6;

   // two-stage synchronisers for all outside inputs
   reg  [NSYNC-1:0]  meta_reg;
   reg  [NSYNC-1:0]  sync_reg;
   reg               clk_d_reg;
   reg               sync_n_d_reg;

   // link shifter
   reg  [23:0]       shift_reg;
   reg  [4:0]        bit_cnt_reg;
   reg  [23:0]       word_reg;
   reg               word_vld_reg;
   reg  [23:0]       dout_shift_reg;
   reg  [23:0]       rb_reg;
   reg  [23:0]       rb_next;

   // function register
   reg               gnd_en_reg;
   reg               dir0_reg;
   reg               val0_reg;
   reg               dir1_reg;
   reg               val1_reg;
   reg               dout_dis_reg;

   wire              link_clk_s;
   wire              link_sync_n_s;
   wire              link_din_s;
   wire              clamp_n_s;
   wire              supply_s;
   wire              aux0_s;
   wire              aux1_s;
   wire              clk_fall;
   wire              frame_start;
   wire              frame_end;
   wire              is_read;
   wire              is_write;
   wire [2:0]        tgt;
   wire [2:0]        chn;
   wire [15:0]       dat;
   reg               wr_code;
   reg               wr_range;
   reg               wr_trim;
   reg               wr_ctrl;
   reg               do_clear;
   wire              clamp_req;
   wire              lvl0;
   wire              lvl1;
   reg  [1:0]        rd_idx;

   assign link_clk_s    = sync_reg[S_CLK];
   assign link_sync_n_s = sync_reg[S_SYNC];
   assign link_din_s    = sync_reg[S_DIN];
   assign clamp_n_s     = sync_reg[S_CLMP];
   assign supply_s      = sync_reg[S_SUP];
   assign aux0_s        = sync_reg[S_AUX0];
   assign aux1_s        = sync_reg[S_AUX1];

   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         // link clock and frame idle high: no false edge right after reset
         meta_reg     <= 7'h60;
         sync_reg     <= 7'h60;
         clk_d_reg    <= 1'b1;
         sync_n_d_reg <= 1'b1;
      end else begin
         meta_reg[S_CLK]  <= i_link_clk;
         meta_reg[S_SYNC] <= i_link_sync_n;
         meta_reg[S_DIN]  <= i_link_din;
         meta_reg[S_CLMP] <= i_clamp_request_n;
         meta_reg[S_SUP]  <= i_supply_ok;
         meta_reg[S_AUX1] <= i_aux_pin_high;
         meta_reg[S_AUX0] <= i_aux_pin_low;
         sync_reg     <= meta_reg;
         clk_d_reg    <= link_clk_s;
         sync_n_d_reg <= link_sync_n_s;
      end
   end

   // data valid on the link clock falling edge
   assign clk_fall    = clk_d_reg & ~link_clk_s;
   assign frame_start = sync_n_d_reg & ~link_sync_n_s;
   assign frame_end   = ~sync_n_d_reg & link_sync_n_s;

   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         shift_reg    <= `WORD_RST;
         bit_cnt_reg  <= 5'h00;
         word_reg     <= `WORD_RST;
         word_vld_reg <= 1'b0;
      end else begin
         word_vld_reg <= 1'b0;
         if (frame_start) begin
            bit_cnt_reg <= 5'h00;
         end else if (!link_sync_n_s && clk_fall) begin
            shift_reg <= {shift_reg[22:0], link_din_s};
            // saturates so an overlong frame never wraps back to one word
            if (bit_cnt_reg != `CNT_MAX)
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
         end
         // only a frame of exactly one word is acted on
         if (frame_end && bit_cnt_reg == `WORD_LEN) begin
            word_reg     <= shift_reg;
            word_vld_reg <= 1'b1;
         end
      end
   end

   // command decode
   assign is_read  = word_vld_reg & word_reg[`RW_BIT];
   assign is_write = word_vld_reg & ~word_reg[`RW_BIT];
   assign tgt      = word_reg[`TGT_HI:`TGT_LO];
   assign chn      = word_reg[`CHN_HI:`CHN_LO];
   assign dat      = word_reg[`DAT_HI:0];

   // write strobes; nop, load and unused codes raise none
   always @* begin
      wr_code  = 1'b0;
      wr_range = 1'b0;
      wr_trim  = 1'b0;
      wr_ctrl  = 1'b0;
      do_clear = 1'b0;
      if (is_write) begin
         case (tgt)
            `TGT_CODE:  wr_code  = 1'b1;
            `TGT_RANGE: wr_range = 1'b1;
            `TGT_TRIM:  wr_trim  = 1'b1;
            `TGT_FUNC: begin
               case (chn)
                  `FN_CTRL:  wr_ctrl  = 1'b1;
                  `FN_CLEAR: do_clear = 1'b1;
                  default:   do_clear = 1'b0;
               endcase
            end
            default:    wr_code  = 1'b0;
         endcase
      end
   end

   assign clamp_req = ~clamp_n_s | ~supply_s;

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : ch
         wire hit;
         // single channel or broadcast; codes above all hit nothing
         assign hit = (chn == `CHN_ALL) || (chn == g[2:0]);
         dac_channel_regs #(
            .CODE_W  (CODE_W),
            .RANGE_W (RANGE_W),
            .TRIM_W  (TRIM_W)
         ) u_chan (
            .i_sys_clk    (i_sys_clk),
            .i_rst_b      (i_rst_b),
            .i_wr_code    (wr_code & hit),
            .i_wr_range   (wr_range & hit),
            .i_wr_trim    (wr_trim & hit),
            .i_clear      (do_clear),
            .i_clamp_req  (clamp_req),
            .i_code       (dat[`CODE_HI:`CODE_LO]),
            .i_range      (dat[`RANGE_HI:0]),
            .i_trim       (dat[`TRIM_HI:0]),
            .o_code       (o_code_field[g*CODE_W +: CODE_W]),
            .o_range      (o_range_code[g*RANGE_W +: RANGE_W]),
            .o_trim       (o_trim_code[g*TRIM_W +: TRIM_W]),
            .o_pos_adj    (o_pos_fs_adj[g*(TRIM_W+1) +: TRIM_W+1]),
            .o_neg_adj    (o_neg_fs_adj[g*(TRIM_W+1) +: TRIM_W+1]),
            .o_amp_gate   (o_amp_gate[g]),
            .o_clamp_gate (o_clamp_gate[g])
         );
      end
   endgenerate

   // function register and aux port
   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         gnd_en_reg   <= 1'b0;
         dir0_reg     <= 1'b0;
         val0_reg     <= 1'b0;
         dir1_reg     <= 1'b0;
         val1_reg     <= 1'b0;
         dout_dis_reg <= 1'b0;
      end else if (wr_ctrl) begin
         gnd_en_reg   <= dat[`FB_GND];
         dir0_reg     <= dat[`FB_DIR0];
         dir1_reg     <= dat[`FB_DIR1];
         dout_dis_reg <= dat[`FB_SDO_DIS];
         if (dat[`FB_DIR0])
            val0_reg <= dat[`FB_VAL0];
         if (dat[`FB_DIR1])
            val1_reg <= dat[`FB_VAL1];
      end
   end

   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_aux_pin_low     <= 1'b0;
         o_aux_pin_low_oe  <= 1'b0;
         o_aux_pin_high    <= 1'b0;
         o_aux_pin_high_oe <= 1'b0;
         o_gnd_offset_en   <= 1'b0;
         o_supply_ok_out   <= 1'b0;
      end else begin
         o_aux_pin_low     <= val0_reg;
         o_aux_pin_low_oe  <= dir0_reg;
         o_aux_pin_high    <= val1_reg;
         o_aux_pin_high_oe <= dir1_reg;
         o_gnd_offset_en   <= gnd_en_reg;
         o_supply_ok_out   <= supply_s;
      end
   end

   // readback word assembly
   assign lvl0   = dir0_reg ? val0_reg : aux0_s;
   assign lvl1   = dir1_reg ? val1_reg : aux1_s;

   // broadcast and unused addresses read back channel 0
   always @* begin
      rd_idx = 2'h0;
      if (chn < `CHN_ALL)
         rd_idx = chn[1:0];
   end

   always @* begin
      rb_next = `RB_RST;
      rb_next[`HDR_HI:`HDR_LO] = word_reg[`HDR_HI:`HDR_LO];
      case (tgt)
         `TGT_CODE:
            rb_next[`DAT_HI:0] = {o_code_field[rd_idx*CODE_W +: CODE_W], `PAD_CODE};
         `TGT_RANGE:
            rb_next[`DAT_HI:0] = {`PAD_RANGE, o_range_code[rd_idx*RANGE_W +: RANGE_W]};
         `TGT_TRIM:
            rb_next[`DAT_HI:0] = {`PAD_TRIM, o_trim_code[rd_idx*TRIM_W +: TRIM_W]};
         `TGT_FUNC:
            if (chn == `FN_CTRL)
               rb_next[`DAT_HI:0] = {`PAD_FUNC, gnd_en_reg, dir1_reg, lvl1,
                                     dir0_reg, lvl0, dout_dis_reg};
         default:
            rb_next[`DAT_HI:0] = 16'h0000;
      endcase
   end

   // read word appears on the next frame, msb first, stepped per falling edge
   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rb_reg         <= `RB_RST;
         dout_shift_reg <= `RB_RST;
         o_link_dout    <= 1'b0;
         o_link_dout_oe <= 1'b0;
      end else begin
         if (is_read)
            rb_reg <= rb_next;
         if (frame_start) begin
            dout_shift_reg <= rb_reg;
            rb_reg         <= `RB_RST;
         end else if (!link_sync_n_s && clk_fall) begin
            dout_shift_reg <= {dout_shift_reg[22:0], 1'b0};
         end
         o_link_dout    <= dout_shift_reg[23];
         o_link_dout_oe <= ~link_sync_n_s & ~dout_dis_reg;
      end
   end

endmodule // quad_dac_channel_register_control

/* logic/quad_dac_regs.vh */
/*
 * Constants for the quad converter command decoder: command word layout,
 * target and channel codes, function register bits and reset values.
 * Assumes inclusion by the design files only; holds definitions only.
 */
`ifndef QUAD_DAC_REGS_VH
`define QUAD_DAC_REGS_VH

// command word layout, 24 bits, first bit on the link is bit 23
`define WORD_LEN        5'h18
`define CNT_MAX         5'h1F
`define RW_BIT          23
`define TGT_HI          21
`define TGT_LO          19
`define CHN_HI          18
`define CHN_LO          16
`define HDR_HI          23
`define HDR_LO          16
`define DAT_HI          15
`define CODE_HI         15
`define CODE_LO         2
`define RANGE_HI        1
`define TRIM_HI         5

// target_select codes
`define TGT_FUNC        3'h0
`define TGT_CODE        3'h2
`define TGT_RANGE       3'h3
`define TGT_TRIM        3'h4

// channel_select codes
`define CHN_ALL         3'h4

// channel_select meaning under the function target
`define FN_NOP          3'h0
`define FN_CTRL         3'h1
`define FN_CLEAR        3'h4
`define FN_LOAD         3'h5

// function register bit positions
`define FB_SDO_DIS      0
`define FB_VAL0         1
`define FB_DIR0         2
`define FB_VAL1         3
`define FB_DIR1         4
`define FB_GND          5

// reset values and readback pad fields
`define CODE_RST        14'h0000
`define RANGE_RST       2'h0
`define TRIM_RST        6'h00
`define WORD_RST        24'h00_0000
`define RB_RST          24'h00_0000
`define PAD_CODE        2'h0
`define PAD_RANGE       14'h0000
`define PAD_TRIM        10'h000
`define PAD_FUNC        10'h000

`endif

/* logic/dac_channel_regs.v */
/*
 * One converter channel: code, range and trim registers, end-point trim
 * offsets and the output clamp gate pair.
 * Assumes write strobes are one-cycle pulses already decoded for this
 * channel and that the clamp request is synchronous to i_sys_clk.
 */
`timescale 1ns/1ps
`include "quad_dac_regs.vh"

module dac_channel_regs #(
   parameter CODE_W  = 14,
   parameter RANGE_W = 2,
   parameter TRIM_W  = 6
) (
   input  wire                 i_sys_clk,
   input  wire                 i_rst_b,
   input  wire                 i_wr_code,
   input  wire                 i_wr_range,
   input  wire                 i_wr_trim,
   input  wire                 i_clear,
   input  wire                 i_clamp_req,
   input  wire [CODE_W-1:0]    i_code,
   input  wire [RANGE_W-1:0]   i_range,
   input  wire [TRIM_W-1:0]    i_trim,
   output reg  [CODE_W-1:0]    o_code,
   output reg  [RANGE_W-1:0]   o_range,
   output reg  [TRIM_W-1:0]    o_trim,
   output reg  [TRIM_W:0]      o_pos_adj,
   output reg  [TRIM_W:0]      o_neg_adj,
   output reg                  o_amp_gate,
   output reg                  o_clamp_gate
);

   wire signed [TRIM_W:0] trim_ext = {i_trim[TRIM_W-1], i_trim};

   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_code    <= `CODE_RST;
         o_range   <= `RANGE_RST;
         o_trim    <= `TRIM_RST;
         o_pos_adj <= {(TRIM_W+1){1'b0}};
         o_neg_adj <= {(TRIM_W+1){1'b0}};
      end else begin
         if (i_clear)
            o_code <= `CODE_RST;
         else if (i_wr_code)
            o_code <= i_code;
         if (i_wr_range)
            o_range <= i_range;
         if (i_wr_trim) begin
            o_trim    <= i_trim;
            // eighth-LSB units: each end moves by half a quarter step
            o_pos_adj <= trim_ext;
            o_neg_adj <= -trim_ext;
         end
      end
   end

   // clamp held until supplies good, no request and a fresh code write
   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_amp_gate   <= 1'b0;
         o_clamp_gate <= 1'b1;
      end else if (i_clamp_req) begin
         o_amp_gate   <= 1'b0;
         o_clamp_gate <= 1'b1;
      end else if (i_wr_code) begin
         o_amp_gate   <= 1'b1;
         o_clamp_gate <= 1'b0;
      end
   end

endmodule // dac_channel_regs

/* test/quad_dac_checker_assertions.sv */
/* concurrent checks on the converter decoder top ports
   assumes binding to quad_dac_channel_register_control, one clock domain */
`timescale 1ns/1ps
module quad_dac_checker #(
   parameter CHANNELS = 4,
   parameter TRIM_W   = 6
) (
   input wire                           i_sys_clk,
   input wire                           i_rst_b,
   input wire                           i_link_sync_n,
   input wire                           o_link_dout_oe,
   input wire                           i_clamp_request_n,
   input wire                           i_supply_ok,
   input wire                           o_supply_ok_out,
   input wire                           o_aux_pin_low_oe,
   input wire [CHANNELS*TRIM_W-1:0]     o_trim_code,
   input wire [CHANNELS*(TRIM_W+1)-1:0] o_pos_fs_adj,
   input wire [CHANNELS*(TRIM_W+1)-1:0] o_neg_fs_adj,
   input wire [CHANNELS-1:0]            o_amp_gate,
   input wire [CHANNELS-1:0]            o_clamp_gate
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);

   a_request_clamps_all: assert property ((!i_clamp_request_n) [*6] |-> &o_clamp_gate && !(|o_amp_gate))
      else $error("clamp request did not clamp all outputs");
   a_supply_clamps_all: assert property ((!i_supply_ok) [*6] |-> &o_clamp_gate && !(|o_amp_gate))
      else $error("supply drop did not clamp all outputs");
   a_gates_paired: assert property (o_amp_gate == ~o_clamp_gate)
      else $error("amplifier and clamp gates not complementary");
   a_supply_out_high: assert property (i_supply_ok [*5] |-> o_supply_ok_out)
      else $error("supply good not shown on output");
   a_supply_out_low: assert property ((!i_supply_ok) [*5] |-> !o_supply_ok_out)
      else $error("supply fault not shown on output");
   a_release_after_frame: assert property ($fell(o_clamp_gate[0]) |-> $past(i_link_sync_n, 3))
      else $error("clamp released outside a completed frame");
   a_dir_after_frame: assert property ($changed(o_aux_pin_low_oe) |-> $past(i_link_sync_n, 3))
      else $error("aux direction changed mid frame");
   a_trim_sign_ext: assert property ($stable(o_trim_code) [*2] |->
      o_pos_fs_adj[TRIM_W:0] == {o_trim_code[TRIM_W-1], o_trim_code[TRIM_W-1:0]})
      else $error("positive end adjust not sign extended trim");
   a_ends_mirror: assert property ($stable(o_trim_code) [*2] |->
      o_neg_fs_adj[TRIM_W:0] == -o_pos_fs_adj[TRIM_W:0])
      else $error("end point adjusts not mirrored");
   a_dout_quiet: assert property (i_link_sync_n [*4] |-> !o_link_dout_oe)
      else $error("readback output enabled outside a frame");
endmodule // quad_dac_checker

bind quad_dac_channel_register_control quad_dac_checker #(.CHANNELS(CHANNELS), .TRIM_W(TRIM_W)) chk (
   .i_sys_clk, .i_rst_b, .i_link_sync_n, .i_clamp_request_n, .i_supply_ok, .o_supply_ok_out,
   .o_link_dout_oe, .o_aux_pin_low_oe, .o_trim_code, .o_pos_fs_adj, .o_neg_fs_adj, .o_amp_gate, .o_clamp_gate);

/* test/host_link.sv */
/* host end of the serial link: sends frames msb first, captures readback
   assumes the device takes data at falling link clock edges */
`timescale 1ns/1ps
module host_link (
   output logic o_link_clk,
   output logic o_sync_n,
   output logic o_din,
   input  wire  i_dout
);
   logic [23:0] rd;
   initial begin
      o_link_clk = 1'b1;
      o_sync_n = 1'b1;
      o_din = 1'b0;
      rd = 24'h00_0000;
   end
   // link clock idles high between frames, period 80 ns
   task automatic send(input logic [23:0] w, input int n);
      o_sync_n = 1'b0;
      #80;
      for (int i = 0; i < n; i++) begin
         o_din = w[23-i];
         #40 o_link_clk = 1'b0;
         rd[23-i] = i_dout;
         #40 o_link_clk = 1'b1;
      end
      #40 o_sync_n = 1'b1;
      o_din = ~o_din;
      #120;
   endtask
endmodule // host_link

/* test/quad_dac_channel_register_control_bench.sv */
/* self-checking bench for the converter command decoder
   assumes host_link drives the link and the checker is bound */
`timescale 1ns/1ps
module quad_dac_channel_register_control_bench;
   typedef struct {int k; int c; logic [23:0] v;} note_t;
   logic        i_sys_clk, i_rst_b, i_clamp_request_n, i_supply_ok, ext_lo, ext_hi, r;
   logic [2:0]  rc;
   wire         link_clk, sync_n, din, dout, sok, gnd, lo_oe, hi_oe, aux_lo, aux_hi;
   wire [55:0]  code_f;
   wire [7:0]   rng_f;
   wire [23:0]  trm_f;
   wire [27:0]  pos_f, neg_f;
   wire [3:0]   amp, clp;
   wire         pin_lo = lo_oe ? aux_lo : ext_lo;
   wire         pin_hi = hi_oe ? aux_hi : ext_hi;
   note_t       exp_q[$];
   note_t       cur;
   event        chk;
   int          n_errors = 0;
   int          cmp_count = 0;
   logic [13:0] code[4];
   logic [1:0]  rng[4];
   logic [5:0]  trm[4];
   logic [3:0]  clamped;
   string       nm[6] = '{"code", "range", "trim", "gates", "control", "aux_out"};

   host_link host (.o_link_clk(link_clk), .o_sync_n(sync_n), .o_din(din), .i_dout(dout));
   quad_dac_channel_register_control dut (
      .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_link_clk(link_clk), .i_link_sync_n(sync_n),
      .i_link_din(din), .o_link_dout(dout), .o_link_dout_oe(), .i_clamp_request_n(i_clamp_request_n),
      .i_supply_ok(i_supply_ok), .o_supply_ok_out(sok), .i_aux_pin_low(pin_lo), .o_aux_pin_low(aux_lo),
      .o_aux_pin_low_oe(lo_oe), .i_aux_pin_high(pin_hi), .o_aux_pin_high(aux_hi), .o_aux_pin_high_oe(hi_oe),
      .o_gnd_offset_en(gnd), .o_code_field(code_f), .o_range_code(rng_f), .o_trim_code(trm_f),
      .o_pos_fs_adj(pos_f), .o_neg_fs_adj(neg_f), .o_amp_gate(amp), .o_clamp_gate(clp));

   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end

   function automatic logic [23:0] seen(input int k, input int c);
      case (k)
         0: return 24'(code_f[c*14+:14]);
         1: return 24'(rng_f[c*2+:2]);
         2: return 24'({pos_f[c*7+:7], neg_f[c*7+:7], trm_f[c*6+:6]});
         3: return 24'({amp, clp});
         4: return 24'({sok, gnd, hi_oe, lo_oe});
         default: return 24'({aux_hi, aux_lo});
      endcase
   endfunction

   task automatic cmp_reg(input int k, input logic [23:0] e, input logic [23:0] s);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %0s exp %h seen %h", nm[k], e, s);
      end
   endtask

   task automatic cmp_rd(input logic [23:0] e, input logic [23:0] s);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value readback exp %h seen %h", e, s);
      end
   endtask

   // monitor: every queued note, oldest first, against what the outputs show now
   initial forever begin
      @(chk);
      while (exp_q.size() > 0) begin
         cur = exp_q.pop_front();
         if (cur.k == 6) cmp_rd(cur.v, host.rd);
         else cmp_reg(cur.k, cur.v, seen(cur.k, cur.c));
      end
   end

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #400_000;
      n_errors++;
      test_done;
   end

   task automatic note(input int k, input int c, input logic [23:0] v);
      exp_q.push_back('{k, c, v});
   endtask

   task automatic note_all;
      for (int c = 0; c < 4; c++) begin
         note(0, c, 24'(code[c]));
         note(1, c, 24'(rng[c]));
         note(2, c, 24'({{trm[c][5], trm[c]}, -{trm[c][5], trm[c]}, trm[c]}));
      end
      note(3, 0, 24'({~clamped, clamped}));
   endtask

   task automatic check(input string t);
      -> chk;
      @(negedge i_sys_clk);
      $display("test %0s done", t);
   endtask

   task automatic frame(input logic [23:0] w, input int n = 24);
      host.send(w, n);
      repeat (10) @(negedge i_sys_clk);
   endtask

   // one write frame, shadow registers follow the addressed channels
   task automatic put(input logic [2:0] t, input logic [2:0] c, input logic [15:0] d);
      frame({2'b00, t, c, d});
      for (int i = 0; i < 4; i++) begin
         if (c == 3'(i) || c == 3'h4) begin
            if (t == 3'h2) {code[i], clamped[i]} = {d[15:2], 1'b0};
            if (t == 3'h3) rng[i] = d[1:0];
            if (t == 3'h4) trm[i] = d[5:0];
            if (t == 3'h0 && c == 3'h4) code[i] = 14'h0000;
         end
      end
   endtask

   // read request, then a no-op frame that carries the answer out
   task automatic rbk(input logic [2:0] t, input logic [2:0] c, input logic [15:0] d);
      frame({2'b10, t, c, 16'h0000});
      frame(24'h00_0000);
      note(6, 0, {2'b10, t, c, d});
      check("readback");
   endtask

   task automatic settle;
      repeat (10) @(negedge i_sys_clk);
   endtask

   initial begin
      i_rst_b = 1'b0;
      i_clamp_request_n = 1'b1;
      i_supply_ok = 1'b1;
      ext_lo = 1'b0;
      ext_hi = 1'b0;
      for (int i = 0; i < 4; i++) {code[i], rng[i], trm[i]} = 22'h00_0000;
      clamped = 4'hF;
      void'($urandom(64513));
      repeat (2) @(negedge i_sys_clk);
      i_rst_b = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      note_all;
      note(4, 0, 24'h8);
      check("reset");
      for (int t = 2; t < 5; t++)
         for (int c = 0; c < 4; c++) put(3'(t), 3'(c), 16'($urandom));
      note_all;
      check("single");
      for (int t = 2; t < 5; t++) put(3'(t), 3'h4, 16'($urandom));
      note_all;
      check("broadcast");
      for (int t = 5; t < 8; t++) begin
         put(3'(t), 3'h1, 16'($urandom));
         put(3'h2, 3'(t), 16'($urandom));
      end
      put(3'h1, 3'h0, 16'($urandom));
      frame({5'h02, 3'h0, 16'($urandom)}, 23);
      note_all;
      check("refused");
      for (int t = 2; t < 5; t++) begin
         rc = 3'($urandom % 4);
         rbk(3'(t), rc, t == 2 ? {code[rc], 2'b00} : t == 3 ? 16'(rng[rc]) : 16'(trm[rc]));
      end
      i_clamp_request_n = 1'b0;
      settle;
      note(3, 0, 24'h0F);
      check("clamp_request");
      i_clamp_request_n = 1'b1;
      clamped = 4'hF;
      settle;
      note(3, 0, 24'h0F);
      check("clamp_held");
      put(3'h2, 3'h1, 16'($urandom));
      note_all;
      check("clamp_release");
      i_supply_ok = 1'b0;
      settle;
      note(3, 0, 24'h0F);
      note(4, 0, 24'h0);
      check("supply_low");
      i_supply_ok = 1'b1;
      clamped = 4'hF;
      settle;
      put(3'h2, 3'h4, 16'($urandom));
      note_all;
      check("supply_back");
      put(3'h0, 3'h4, 16'($urandom));
      note_all;
      check("clear");
      r = 1'($urandom);
      ext_lo = ~r;
      ext_hi = ~r;
      put(3'h0, 3'h1, {10'h000, 1'b1, 1'b1, r, 1'b0, r, 1'b0});
      note(4, 0, 24'hE);
      note(5, 0, {22'h00_0000, r, 1'b0});
      check("aux_setup");
      rbk(3'h0, 3'h1, {10'h000, 1'b1, 1'b1, r, 1'b0, ~r, 1'b0});
      put(3'h0, 3'h1, {10'h000, 1'b0, 1'b0, ~r, 1'b1, 1'b1, 1'b0});
      note(4, 0, 24'h9);
      note(5, 0, {22'h00_0000, r, 1'b1});
      check("aux_flip");
      test_done;
   end
endmodule // quad_dac_channel_register_control_bench
